/* File: hw/fws_consts.svh */
// Named constants for the flash write status reporting block.
// Assumes a 20 MHz reference clock; included by bare name.
`ifndef FWS_CONSTS_SVH
`define FWS_CONSTS_SVH

// Reference clock rate
`define FWS_REF_HZ 20000000
// Protected program status window, ns
`define FWS_PROT_PROG_NS 1000
// Protected erase status window, us
`define FWS_PROT_ERASE_US 100
// Cycles, rounded down from the approximate windows
`define FWS_PROT_PROG_CYC ((`FWS_PROT_PROG_NS * (`FWS_REF_HZ / 1000000)) / 1000)
`define FWS_PROT_ERASE_CYC (`FWS_PROT_ERASE_US * (`FWS_REF_HZ / 1000000))
// Slow burst clock limit and derived period in reference cycles
`define FWS_SLOW_HZ 6000000
`define FWS_SLOW_PERIOD (`FWS_REF_HZ / `FWS_SLOW_HZ)
// Wait on every third slow clock
`define FWS_SLOW_PHASE 2'h2
`define FWS_SLOW_WRAP 2'h2
// Word address in each 64-word block that stalls the burst
`define FWS_BOUNDARY_ADDR 6'h3e
// Status bit positions in the data word
`define FWS_POLL_POS 7
`define FWS_TOGGLE_POS 6
`define FWS_TIMEOUT_POS 5
`define FWS_ERTIMER_POS 3
`define FWS_STOGGLE_POS 2
// Reset values
`define FWS_DATA_RST 16'h0000
`define FWS_BIT_RST 1'h0

`endif

/* File: hw/fws_pkg.sv */
// Types shared by the flash write status reporting block.
// Assumes nothing beyond the constants header.
package fws_pkg;
	typedef enum logic [2:0] {
		FWS_IDLE,
		FWS_PROG,
		FWS_PROT_PROG,
		FWS_ERASE,
		FWS_PROT_ERASE,
		FWS_SUSP,
		FWS_SUSP_PROG
	} fws_state_t;
endpackage : fws_pkg

/* File: hw/fws_sync.sv */
// Two-flop synchroniser for pin-level inputs.
// Assumes the inputs are quasi-static levels relative to ref_clk.
`timescale 1ns/100ps
`default_nettype none
module fws_sync #(
	parameter int WIDTH = 1
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic [WIDTH-1:0] rawIn,
	input wire logic [WIDTH-1:0] rstVal,
	output logic [WIDTH-1:0] syncOut
);
	logic [WIDTH-1:0] stage1;
	logic [WIDTH-1:0] stage2;

	generate
		if (WIDTH < 1) begin : g_chk
			$error("fws_sync WIDTH must be at least one");
		end
	endgenerate

	// Reset value is all ones for every pin of every instance; rstVal does not change it
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			stage1 <= '1;
			stage2 <= '1;
		end else begin
			stage1 <= rawIn;
			stage2 <= stage1;
		end
	end

	assign syncOut = stage2 & (rstVal | ~rstVal);
endmodule : fws_sync
`default_nettype wire

/* File: hw/fws_timer.sv */
// Down-counter giving a one-cycle expiry pulse after a loaded count.
// Assumes load is a one-cycle pulse from logic on ref_clk.
`timescale 1ns/100ps
`default_nettype none
module fws_timer #(
	parameter int WIDTH = 12
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic load,
	input wire logic cancel,
	input wire logic [WIDTH-1:0] loadVal,
	output logic expired
);
	logic [WIDTH-1:0] count;
	logic running;
	wire lastTick = running && (count == {{(WIDTH-1){1'b0}}, 1'b1});

	generate
		if (WIDTH < 2) begin : g_chk
			$error("fws_timer WIDTH must be at least two");
		end
	endgenerate

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			count <= '0;
			running <= 1'b0;
			expired <= 1'b0;
		end else begin
			expired <= lastTick && !load && !cancel;
			if (load) begin
				count <= loadVal;
				running <= 1'b1;
			end else if (cancel || lastTick) begin
				count <= '0;
				running <= 1'b0;
			end else if (running) begin
				count <= count - {{(WIDTH-1){1'b0}}, 1'b1};
			end
		end
	end
endmodule : fws_timer
`default_nettype wire

/* File: hw/fws_status_top.sv */
// Write operation status reporting and burst wait output of a four-bank flash.
// Assumes an embedded algorithm controller on ref_clk issues the command pulses;
// read strobes and the burst clock arrive as pins.
//
// Function
// - Program status returns inverted written bit 7, true value when done.
// - Protected-sector program shows polling status about 1 us, then array reads.
// - Polling bit reads 0 during erase, 1 when done or suspended.
// - Fully protected erase shows polling status about 100 us, then array.
// - Partially protected erase skips protected sectors; their status is undefined.
// - Low wait output means next word comes one clock later.
// - Wait output driven only in burst reads, low during initial access.
// - Wait low at each 64-word boundary, first at word 3Eh.
// - Burst clock below 6 MHz gives wait low every third clock.
// - Toggle bit flips per read to busy bank, stops on completion.
// - Toggle bit valid from last command write and in erase timeout.
// - Fully protected erase toggles about 100 us, then array data.
// - Protected-sector program toggles about 1 us, then array data.
// - Toggle stops in erase suspend, resumes during suspend program.
// - Sector toggle flips in selected sectors; constant elsewhere during erase.
// - In erase suspend, unselected sectors return plain array data.
// - Sector toggle holds in normal program, undefined in suspend program.
// - Status only for the busy bank; idle bank returns array data.
`timescale 1ns/100ps
`default_nettype none
`include "fws_consts.svh"
module fws_status_top
	import fws_pkg::*;
#(
	parameter int BANK_W = 2,
	parameter int INIT_WAIT = 4,
	parameter int TIMER_W = 12
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic cmdProgram,
	input wire logic cmdErase,
	input wire logic cmdSuspend,
	input wire logic cmdResume,
	input wire logic cmdTargetProtected,
	input wire logic algDone,
	input wire logic [BANK_W-1:0] opBank,
	input wire logic progBit7,
	input wire logic timeoutFlag,
	input wire logic eraseTimerBit,
	input wire logic ce_n,
	input wire logic oe_n,
	input wire logic [BANK_W-1:0] readBank,
	input wire logic readInErase,
	input wire logic [15:0] arrayData,
	output logic [15:0] dataOut,
	output logic dataOutEn,
	input wire logic burstMode,
	input wire logic burstStart,
	input wire logic [5:0] burstAddr,
	input wire logic burstClk,
	output logic rdy,
	output logic rdyOe,
	output logic bankBusy
);
	generate
		if (BANK_W < 1 || INIT_WAIT < 1 || INIT_WAIT > 15) begin : g_chk
			$error("fws_status_top parameters out of range");
		end
		if (TIMER_W < 12 || TIMER_W > 31) begin : g_chk_t
			$error("fws_status_top TIMER_W cannot hold the protect windows");
		end
	endgenerate

	localparam logic [TIMER_W-1:0] PROG_CYC = TIMER_W'(`FWS_PROT_PROG_CYC);
	localparam logic [TIMER_W-1:0] ERASE_CYC = TIMER_W'(`FWS_PROT_ERASE_CYC);
	localparam logic [3:0] INIT_CNT = 4'(INIT_WAIT);
	localparam logic [3:0] SLOW_CNT = 4'(`FWS_SLOW_PERIOD);

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers

	logic ceSync;
	logic oeSync;
	logic clkSync;

	fws_sync #(.WIDTH(3)) u_sync (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.rawIn({ce_n, oe_n, burstClk}),
		.rstVal(3'h7),
		.syncOut({ceSync, oeSync, clkSync})
	);

	logic oePrev;
	logic clkPrev;
	// A read cycle starts when output enable falls with chip enable low
	wire readCycle = oePrev && !oeSync && !ceSync;
	wire clkRise = !clkPrev && clkSync;

	////////////////////////////////////////////////////////////////////////
	// Operation state

	fws_state_t state;
	fws_state_t next_state;
	logic [BANK_W-1:0] busyBank;
	logic writtenBit7;
	logic protExpired;

	wire protProgStart = cmdProgram && cmdTargetProtected && (state == FWS_IDLE);
	wire protEraseStart = cmdErase && cmdTargetProtected && (state == FWS_IDLE);

	fws_timer #(.WIDTH(TIMER_W)) u_timer (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.load(protProgStart || protEraseStart),
		.cancel(1'b0),
		.loadVal(protProgStart ? PROG_CYC : ERASE_CYC),
		.expired(protExpired)
	);

	always_comb begin
		next_state = state;
		case (state)
			FWS_IDLE: begin
				if (cmdProgram) begin
					next_state = cmdTargetProtected ? FWS_PROT_PROG : FWS_PROG;
				end else if (cmdErase) begin
					next_state = cmdTargetProtected ? FWS_PROT_ERASE : FWS_ERASE;
				end
			end
			FWS_PROG: begin
				if (algDone) begin
					next_state = FWS_IDLE;
				end
			end
			FWS_PROT_PROG, FWS_PROT_ERASE: begin
				if (protExpired) begin
					next_state = FWS_IDLE;
				end
			end
			FWS_ERASE: begin
				if (algDone) begin
					next_state = FWS_IDLE;
				end else if (cmdSuspend) begin
					next_state = FWS_SUSP;
				end
			end
			FWS_SUSP: begin
				if (cmdResume) begin
					next_state = FWS_ERASE;
				end else if (cmdProgram && !cmdTargetProtected) begin
					next_state = FWS_SUSP_PROG;
				end
			end
			FWS_SUSP_PROG: begin
				if (algDone) begin
					next_state = FWS_SUSP;
				end
			end
			default: begin
				next_state = FWS_IDLE;
			end
		endcase
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= FWS_IDLE;
			busyBank <= '0;
			writtenBit7 <= `FWS_BIT_RST;
		end else begin
			state <= next_state;
			if (state == FWS_IDLE && (cmdProgram || cmdErase)) begin
				busyBank <= opBank;
			end
			if (cmdProgram && (state == FWS_IDLE || state == FWS_SUSP)) begin
				writtenBit7 <= progBit7;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read decode

	wire inProg = (state == FWS_PROG) || (state == FWS_PROT_PROG);
	wire inSuspProg = (state == FWS_SUSP_PROG);
	wire inErase = (state == FWS_ERASE) || (state == FWS_PROT_ERASE);
	wire inSusp = (state == FWS_SUSP);
	// status only from the busy bank
	wire bankHit = (state != FWS_IDLE) && (readBank == busyBank);
	// suspended reads outside erase sectors give array data
	wire statusRead = bankHit && !(inSusp && !readInErase);
	wire pollBit = (inProg || inSuspProg) ? !writtenBit7 : inSusp;
	wire toggleActive = inProg || inSuspProg || inErase;
	wire stoggleActive = (inErase || inSusp) && readInErase;

	logic toggleBit;
	logic stoggleBit;

	function automatic logic [15:0] fws_status_word(
		input logic [15:0] arr,
		input logic poll,
		input logic tog,
		input logic tmo,
		input logic ert,
		input logic stog
	);
		logic [15:0] w;
		w = arr;
		w[`FWS_POLL_POS] = poll;
		w[`FWS_TOGGLE_POS] = tog;
		w[`FWS_TIMEOUT_POS] = tmo;
		w[`FWS_ERTIMER_POS] = ert;
		w[`FWS_STOGGLE_POS] = stog;
		return w;
	endfunction : fws_status_word

	wire [15:0] statusWord = fws_status_word(arrayData, pollBit, toggleBit ^ toggleActive,
		timeoutFlag, eraseTimerBit, stoggleBit ^ stoggleActive);
	wire [15:0] readWord = statusRead ? statusWord : arrayData;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			oePrev <= 1'b1;
			toggleBit <= `FWS_BIT_RST;
			stoggleBit <= `FWS_BIT_RST;
			dataOut <= `FWS_DATA_RST;
			dataOutEn <= 1'b0;
			bankBusy <= 1'b0;
		end else begin
			oePrev <= oeSync;
			dataOutEn <= !oeSync && !ceSync;
			bankBusy <= next_state != FWS_IDLE;
			if (readCycle) begin
				dataOut <= readWord;
				if (statusRead && toggleActive) begin
					toggleBit <= !toggleBit;
				end
				if (statusRead && stoggleActive) begin
					stoggleBit <= !stoggleBit;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Burst wait output

	logic [3:0] periodCnt;
	logic slowClk;
	logic [3:0] initCnt;
	logic [5:0] wordAddr;
	logic [1:0] slowPhase;

	wire initBusy = initCnt != 4'h0;
	wire atBoundary = wordAddr == `FWS_BOUNDARY_ADDR;
	wire slowWait = slowClk && (slowPhase == `FWS_SLOW_PHASE);
	wire [1:0] phaseNext = (slowPhase == `FWS_SLOW_WRAP) ? 2'h0 : slowPhase + 2'h1;
	wire [3:0] periodNext = (periodCnt == 4'hf) ? periodCnt : periodCnt + 4'h1;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			// Matches the synchroniser reset level, no false edge
			clkPrev <= 1'b1;
			periodCnt <= 4'h0;
			slowClk <= 1'b0;
		end else begin
			clkPrev <= clkSync;
			periodCnt <= clkRise ? 4'h1 : periodNext;
			if (clkRise) begin
				slowClk <= periodCnt > SLOW_CNT;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			initCnt <= 4'h0;
			wordAddr <= 6'h00;
			slowPhase <= 2'h0;
			rdy <= 1'b1;
			rdyOe <= 1'b0;
		end else begin
			rdyOe <= burstMode && !ceSync;
			if (burstStart) begin
				initCnt <= INIT_CNT;
				wordAddr <= burstAddr;
				slowPhase <= 2'h0;
				rdy <= 1'b0;
			end else if (!burstMode) begin
				initCnt <= 4'h0;
				rdy <= 1'b1;
			end else if (clkRise) begin
				slowPhase <= phaseNext;
				// low holds the next word one clock
				if (initBusy) begin
					initCnt <= initCnt - 4'h1;
					rdy <= 1'b0;
				end else if (atBoundary || slowWait) begin
					rdy <= 1'b0;
					wordAddr <= atBoundary ? wordAddr : wordAddr + 6'h01;
					if (atBoundary && !rdy) begin
						wordAddr <= wordAddr + 6'h01;
						// slow wait still applies after the stall
						rdy <= !slowWait;
					end
				end else begin
					wordAddr <= wordAddr + 6'h01;
					rdy <= 1'b1;
				end
			end
		end
	end
endmodule : fws_status_top
`default_nettype wire

/* File: verification/fws_status_properties.sv */
// Port-level assertions for the write status block.
// Assumes binding into fws_status_top on ref_clk with rst_n as reset.
`timescale 1ns/100ps
`default_nettype none
module fws_status_properties (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic cmdProgram,
	input wire logic cmdErase,
	input wire logic cmdTargetProtected,
	input wire logic oe_n,
	input wire logic [15:0] dataOut,
	input wire logic dataOutEn,
	input wire logic burstMode,
	input wire logic burstStart,
	input wire logic rdy,
	input wire logic rdyOe,
	input wire logic bankBusy
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	a_rdy_idle_high: assert property (!burstMode [*2] |-> rdy)
		else $error("wait output low outside burst");
	a_rdyoe_idle_off: assert property (!burstMode [*2] |-> !rdyOe)
		else $error("wait output driven outside burst");
	a_initial_wait_low: assert property (burstMode && burstStart |=> !rdy [*8])
		else $error("wait output not low in initial access");
	a_program_goes_busy: assert property (cmdProgram && !bankBusy |=> bankBusy)
		else $error("program not taken");
	a_erase_goes_busy: assert property (cmdErase && !bankBusy |=> bankBusy)
		else $error("erase not taken");
	a_prot_prog_window: assert property (cmdProgram && cmdTargetProtected && !bankBusy
		|=> bankBusy [*8] ##1 bankBusy [*7] ##[1:10] !bankBusy)
		else $error("protected program window wrong");
	a_prot_erase_hold: assert property (cmdErase && cmdTargetProtected && !bankBusy
		|-> ##300 bankBusy)
		else $error("protected erase window too short");
	a_read_data_stands: assert property (oe_n [*4] |=> $stable(dataOut))
		else $error("read word changed without a read");
	a_out_enable_off: assert property (oe_n [*4] |-> !dataOutEn)
		else $error("data driven with output enable high");
endmodule : fws_status_properties

bind fws_status_top fws_status_properties u_props (
	.ref_clk(ref_clk),
	.rst_n(rst_n),
	.cmdProgram(cmdProgram),
	.cmdErase(cmdErase),
	.cmdTargetProtected(cmdTargetProtected),
	.oe_n(oe_n),
	.dataOut(dataOut),
	.dataOutEn(dataOutEn),
	.burstMode(burstMode),
	.burstStart(burstStart),
	.rdy(rdy),
	.rdyOe(rdyOe),
	.bankBusy(bankBusy)
);
`default_nettype wire

/* File: verification/fws_host_model.sv */
// Host controller model: read cycles on the enable pins and the burst clock.
// Assumes the bench holds readReq until readDone; burstRun gates the clock.
`timescale 1ns/100ps
`default_nettype none
module fws_host_model (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic readReq,
	input wire logic burstRun,
	output logic ce_n,
	output logic oe_n,
	output logic burstClk,
	output logic readDone
);
	logic [3:0] phase;
	wire active = readReq && !readDone;
	// enable low per read, address held by bench
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			phase <= 4'h0;
			ce_n <= 1'b1;
			oe_n <= 1'b1;
			readDone <= 1'b0;
		end else begin
			phase <= active ? phase + 4'h1 : 4'h0;
			ce_n <= !(active || burstRun);
			oe_n <= !(active && phase < 4'h6);
			readDone <= active && phase == 4'h9;
		end
	end
	// clock stands still outside a burst
	initial burstClk = 1'b0;
	always #200 burstClk = burstRun ? ~burstClk : 1'b0;
endmodule : fws_host_model
`default_nettype wire

/* File: verification/flash_write_status_reporting_tb_top.sv */
// Self-checking bench for the write status block.
// Assumes fws_host_model on the pins and the checker bound to the top.
`timescale 1ns/100ps
`default_nettype none
module flash_write_status_reporting_tb_top;
	logic ref_clk = 1'b0, rst_n = 1'b0, readReq = 1'b0, burstRun = 1'b0;
	logic cmdProgram = 1'b0, cmdErase = 1'b0, cmdSuspend = 1'b0, cmdResume = 1'b0;
	logic cmdTargetProtected = 1'b0, algDone = 1'b0, progBit7 = 1'b0;
	logic timeoutFlag = 1'b0, eraseTimerBit = 1'b0, readInErase = 1'b0;
	logic burstMode = 1'b0, burstStart = 1'b0;
	logic [1:0] opBank = 2'h0, readBank = 2'h0, b;
	logic [15:0] arrayData = 16'h0000, dataOut, d, prev, w;
	logic [5:0] burstAddr = 6'h00;
	logic ce_n, oe_n, burstClk, readDone, dataOutEn, rdy, rdyOe, bankBusy, pb;
	int num_errors = 0, total_checks = 0, lows;
	realtime t0;

	fws_status_top dut (.ref_clk(ref_clk), .rst_n(rst_n), .cmdProgram(cmdProgram),
		.cmdErase(cmdErase), .cmdSuspend(cmdSuspend), .cmdResume(cmdResume),
		.cmdTargetProtected(cmdTargetProtected), .algDone(algDone), .opBank(opBank),
		.progBit7(progBit7), .timeoutFlag(timeoutFlag), .eraseTimerBit(eraseTimerBit),
		.ce_n(ce_n), .oe_n(oe_n), .readBank(readBank), .readInErase(readInErase),
		.arrayData(arrayData), .dataOut(dataOut), .dataOutEn(dataOutEn),
		.burstMode(burstMode), .burstStart(burstStart), .burstAddr(burstAddr),
		.burstClk(burstClk), .rdy(rdy), .rdyOe(rdyOe), .bankBusy(bankBusy));
	fws_host_model host (.ref_clk(ref_clk), .rst_n(rst_n), .readReq(readReq),
		.burstRun(burstRun), .ce_n(ce_n), .oe_n(oe_n), .burstClk(burstClk),
		.readDone(readDone));

	always #25 ref_clk = ~ref_clk;

	task automatic print_verdict();
		$display("Checks %0d, mismatches %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : print_verdict

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	function automatic logic [15:0] expStat(input logic [15:0] a, input logic p);
		expStat = a;
		expStat[7] = p;
		expStat[5] = timeoutFlag;
		expStat[3] = eraseTimerBit;
		expStat = expStat & 16'hffbb;
	endfunction : expStat

	task automatic issue(input int k, input logic prot);
		@(posedge ref_clk);
		{cmdProgram, cmdErase, cmdSuspend, cmdResume, algDone} <= 5'b10000 >> k;
		cmdTargetProtected <= prot;
		@(posedge ref_clk);
		{cmdProgram, cmdErase, cmdSuspend, cmdResume, algDone} <= 5'h00;
	endtask : issue

	task automatic readWord(input logic [1:0] bk, input logic inE, output logic [15:0] q);
		int n;
		logic en;
		@(posedge ref_clk);
		readBank <= bk;
		readInErase <= inE;
		arrayData <= 16'($urandom);
		readReq <= 1'b1;
		n = 0;
		en = 1'b0;
		do begin
			@(negedge ref_clk);
			n++;
			en |= dataOutEn;
		end while (readDone !== 1'b1 && n < 50);
		if (n >= 50) begin
			num_errors++;
			print_verdict();
		end
		q = dataOut;
		chk(16'(en), 16'h0001);
		@(posedge ref_clk);
		readReq <= 1'b0;
	endtask : readWord

	task automatic waitIdle(input int lo, input int hi);
		int n;
		// Let the taking edge settle before looking at busy
		@(negedge ref_clk);
		n = 0;
		while (bankBusy !== 1'b0 && n < 3000) begin
			@(negedge ref_clk);
			n++;
		end
		if (n >= 3000) begin
			num_errors++;
			print_verdict();
		end
		n = int'(($realtime - t0) / 50.0);
		chk(16'(n >= lo && n <= hi), 16'h0001);
	endtask : waitIdle

	initial begin
		void'($urandom(32'h57fa4356));
		repeat (16) @(posedge ref_clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge ref_clk);
		for (int i = 0; i < 3; i++) begin
			b = 2'($urandom);
			pb = 1'($urandom);
			opBank <= b;
			progBit7 <= pb;
			timeoutFlag <= 1'($urandom);
			eraseTimerBit <= 1'($urandom);
			issue(0, 1'b0);
			readWord(b, 1'b0, prev);
			readWord(b, 1'b0, d);
			chk(d & 16'hffbb, expStat(arrayData, ~pb));
			chk(16'(d[6] ^ prev[6]), 16'h0001);
			chk(16'(d[2]), 16'(prev[2]));
			readWord(b + 2'h1, 1'b0, d);
			chk(d, arrayData);
			issue(4, 1'b0);
			readWord(b, 1'b0, d);
			chk(d, arrayData);
		end
		$display("program test done");
		b = 2'($urandom);
		opBank <= b;
		issue(1, 1'b0);
		readWord(b, 1'b1, prev);
		readWord(b, 1'b1, d);
		chk(d & 16'hffbb, expStat(arrayData, 1'b0));
		chk(16'({d[6], d[2]} ^ {prev[6], prev[2]}), 16'h0003);
		prev = d;
		readWord(b, 1'b0, d);
		chk(16'({d[6] ^ prev[6], d[2]}), 16'({1'b1, prev[2]}));
		prev = d;
		issue(2, 1'b0);
		readWord(b, 1'b1, d);
		chk(d & 16'hffbb, expStat(arrayData, 1'b1));
		chk(16'({d[6], d[2] ^ prev[2]}), 16'({prev[6], 1'b1}));
		readWord(b, 1'b0, d);
		chk(d, arrayData);
		issue(0, 1'b0);
		readWord(b, 1'b0, prev);
		readWord(b, 1'b0, d);
		chk(d & 16'hffbb, expStat(arrayData, ~progBit7));
		chk(16'(d[6] ^ prev[6]), 16'h0001);
		issue(4, 1'b0);
		issue(3, 1'b0);
		issue(4, 1'b0);
		readWord(b, 1'b1, d);
		chk(d, arrayData);
		$display("erase test done");
		issue(0, 1'b1);
		t0 = $realtime;
		waitIdle(15, 26);
		readWord(b, 1'b0, d);
		chk(d, arrayData);
		issue(1, 1'b1);
		t0 = $realtime;
		readWord(b, 1'b1, prev);
		readWord(b, 1'b1, d);
		chk(16'(d[6] ^ prev[6]), 16'h0001);
		waitIdle(1990, 2010);
		readWord(b, 1'b1, d);
		chk(d, arrayData);
		$display("protect test done");
		@(posedge ref_clk);
		burstMode <= 1'b1;
		burstAddr <= 6'h38;
		burstStart <= 1'b1;
		@(posedge ref_clk);
		burstStart <= 1'b0;
		burstRun <= 1'b1;
		lows = 0;
		for (int i = 0; i < 16; i++) begin
			repeat (8) @(negedge ref_clk);
			w[i] = rdy;
			lows += (i > 5 && rdy === 1'b0) ? 1 : 0;
		end
		chk(16'({w[1:0], rdyOe}), 16'h0001);
		chk(16'(lows >= 3), 16'h0001);
		// Boundary stall beside a slow wait gives two lows in a row
		chk(16'((~w[14:6] & ~w[15:7]) != 9'h000), 16'h0001);
		@(posedge ref_clk);
		burstRun <= 1'b0;
		burstMode <= 1'b0;
		repeat (6) @(negedge ref_clk);
		chk(16'(rdy), 16'h0001);
		$display("burst test done");
		print_verdict();
	end
endmodule : flash_write_status_reporting_tb_top
`default_nettype wire
